// *** rtl/alu_if.sv ***
// Operand and result bundle between the sequencer and the arithmetic unit
`timescale 1ns/100ps
interface alu_if;
  logic [3:0] op;
  logic [7:0] work;
  logic [7:0] mem;
  logic [5:0] flags_in;
  logic [7:0] result;
  logic [5:0] flags_out;
  modport alu (input op, input work, input mem, input flags_in, output result, output flags_out);
  modport core (output op, output work, output mem, output flags_in, input result, input flags_out);
endinterface

// *** rtl/ext_exec.sv ***
// Executor for the subtract, swap, skip, table read and XOR instructions
// Functional notes
// - Subtract memory from work, result to memory
// - Borrow-inverse flag clear when result negative
// - Swap nibbles in place, flags untouched
// - Swapped byte to work, memory untouched
// - Skip next when addressed byte is zero
// - Taken skip adds one dummy cycle
// - Copy byte to work, skip if zero
// - Skip next when selected bit is zero
// - Paged table read: low byte memory, high latch
// - Last-page table read uses only low pointer
// - Pre-increment low pointer, then paged read
// - Pre-increment, last-page read, flags untouched
// - XOR into work, only zero flag
// - XOR into memory, only zero flag
`timescale 1ns/100ps
module ext_exec (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [3:0] op_i,
  input wire logic [9:0] addr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic work_load_i,
  input wire logic [7:0] work_i,
  input wire logic tbl_load_i,
  input wire logic [7:0] table_low_pointer_i,
  input wire logic [7:0] table_page_pointer_i,
  input wire logic [7:0] dm_rdata_i,
  input wire logic [15:0] pm_rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic skip_o,
  output logic [9:0] dm_addr_o,
  output logic dm_we_o,
  output logic [7:0] dm_wdata_o,
  output logic [13:0] pm_addr_o,
  output logic [7:0] work_o,
  output logic [5:0] flags_o,
  output logic [7:0] table_low_pointer_o,
  output logic [7:0] table_high_latch_o
);
  ext_exec_pkg::state_t state_q;
  logic [3:0] op_q;
  logic [2:0] bit_q;
  logic [9:0] addr_q;
  logic [13:0] pm_addr_q;
  logic [7:0] work_q;
  logic [5:0] flags_q;
  logic [7:0] table_low_pointer_q;
  logic [7:0] table_page_pointer_q;
  logic [7:0] table_high_latch_q;
  logic dm_we_q;
  logic [7:0] dm_wdata_q;
  logic done_q;
  logic skip_q;
  logic accept;
  logic preinc;
  logic skip_c;
  logic mem_write_c;
  logic [7:0] table_low_pointer_next;

  alu_if alu_bus ();

  ext_exec_alu u_alu (
    .a(alu_bus.alu)
  );

  assign alu_bus.op = op_q;
  assign alu_bus.work = work_q;
  assign alu_bus.mem = dm_rdata_i;
  assign alu_bus.flags_in = flags_q;

  function automatic logic [13:0] table_addr(input logic last, input logic [7:0] page, input logic [7:0] low);
    table_addr = last ? {ext_exec_pkg::LAST_PAGE, low} : {page[5:0], low};
  endfunction

  function automatic logic is_table(input logic [3:0] op);
    is_table = (op == ext_exec_pkg::OP_TABLE_READ_PAGED) || (op == ext_exec_pkg::OP_TABLE_READ_LAST_PAGE)
      || (op == ext_exec_pkg::OP_PREINC_TABLE_READ_PAGED) || (op == ext_exec_pkg::OP_PREINC_TABLE_READ_LAST);
  endfunction

  assign accept = start_i && (state_q == ext_exec_pkg::ST_IDLE);
  assign preinc = (op_i == ext_exec_pkg::OP_PREINC_TABLE_READ_PAGED)
    || (op_i == ext_exec_pkg::OP_PREINC_TABLE_READ_LAST);
  assign table_low_pointer_next = preinc ? table_low_pointer_q + 8'h01 : table_low_pointer_q;

  always_comb begin
    skip_c = 1'b0;
    unique case (op_q)
      ext_exec_pkg::OP_SKIP_IF_ZERO_BYTE, ext_exec_pkg::OP_LOAD_SKIP_IF_ZERO: begin
        skip_c = (dm_rdata_i == 8'h00);
      end
      ext_exec_pkg::OP_SKIP_IF_ZERO_BIT: begin
        skip_c = ~dm_rdata_i[bit_q];
      end
      default: begin
        skip_c = 1'b0;
      end
    endcase
  end

  assign mem_write_c = (op_q == ext_exec_pkg::OP_SUB_TO_MEMORY) || (op_q == ext_exec_pkg::OP_NIBBLE_SWAP_IN_PLACE)
    || (op_q == ext_exec_pkg::OP_XOR_TO_MEMORY) || is_table(op_q);

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_q <= ext_exec_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        ext_exec_pkg::ST_IDLE: begin
          if (start_i) begin
            state_q <= ext_exec_pkg::ST_FETCH;
          end
        end
        ext_exec_pkg::ST_FETCH: begin
          state_q <= ext_exec_pkg::ST_EXEC;
        end
        ext_exec_pkg::ST_EXEC: begin
          // Skipped word is fetched but discarded, hence the extra cycle
          state_q <= skip_c ? ext_exec_pkg::ST_DUMMY : ext_exec_pkg::ST_IDLE;
        end
        ext_exec_pkg::ST_DUMMY: begin
          state_q <= ext_exec_pkg::ST_IDLE;
        end
        default: begin
          state_q <= ext_exec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      op_q <= ext_exec_pkg::OP_SUB_TO_MEMORY;
      bit_q <= ext_exec_pkg::BIT_RST;
      addr_q <= ext_exec_pkg::ADDR_RST;
      pm_addr_q <= ext_exec_pkg::PM_ADDR_RST;
    end else if (accept) begin
      op_q <= op_i;
      bit_q <= bit_sel_i;
      addr_q <= addr_i;
      pm_addr_q <= table_addr((op_i == ext_exec_pkg::OP_TABLE_READ_LAST_PAGE)
        || (op_i == ext_exec_pkg::OP_PREINC_TABLE_READ_LAST), table_page_pointer_q, table_low_pointer_next);
    end
  end

  // Pointer load from outside is ignored while an instruction owns the pointer
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      table_low_pointer_q <= ext_exec_pkg::TABLE_LOW_POINTER_RST;
      table_page_pointer_q <= ext_exec_pkg::TABLE_PAGE_POINTER_RST;
    end else if (accept) begin
      table_low_pointer_q <= table_low_pointer_next;
    end else if (tbl_load_i && state_q == ext_exec_pkg::ST_IDLE) begin
      table_low_pointer_q <= table_low_pointer_i;
      table_page_pointer_q <= table_page_pointer_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      work_q <= ext_exec_pkg::WORK_RST;
    end else if (state_q == ext_exec_pkg::ST_EXEC) begin
      if (op_q == ext_exec_pkg::OP_NIBBLE_SWAP_TO_WORK || op_q == ext_exec_pkg::OP_XOR_TO_WORK) begin
        work_q <= alu_bus.result;
      end else if (op_q == ext_exec_pkg::OP_LOAD_SKIP_IF_ZERO) begin
        work_q <= dm_rdata_i;
      end
    end else if (work_load_i && state_q == ext_exec_pkg::ST_IDLE) begin
      work_q <= work_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      flags_q <= ext_exec_pkg::FLAGS_RST;
    end else if (state_q == ext_exec_pkg::ST_EXEC) begin
      flags_q <= alu_bus.flags_out;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      table_high_latch_q <= ext_exec_pkg::TABLE_HIGH_LATCH_RST;
      dm_we_q <= 1'b0;
      dm_wdata_q <= ext_exec_pkg::WDATA_RST;
    end else begin
      dm_we_q <= (state_q == ext_exec_pkg::ST_EXEC) && mem_write_c;
      if (state_q == ext_exec_pkg::ST_EXEC) begin
        dm_wdata_q <= is_table(op_q) ? pm_rdata_i[7:0] : alu_bus.result;
        if (is_table(op_q)) begin
          table_high_latch_q <= pm_rdata_i[15:8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      done_q <= ((state_q == ext_exec_pkg::ST_EXEC) && !skip_c) || (state_q == ext_exec_pkg::ST_DUMMY);
      skip_q <= state_q == ext_exec_pkg::ST_DUMMY;
    end
  end

  assign busy_o = state_q != ext_exec_pkg::ST_IDLE;
  assign done_o = done_q;
  assign skip_o = skip_q;
  assign dm_addr_o = addr_q;
  assign dm_we_o = dm_we_q;
  assign dm_wdata_o = dm_wdata_q;
  assign pm_addr_o = pm_addr_q;
  assign work_o = work_q;
  assign flags_o = flags_q;
  assign table_low_pointer_o = table_low_pointer_q;
  assign table_high_latch_o = table_high_latch_q;

  logic [7:0] sub_chk;
  logic [7:0] swap_chk;
  logic [7:0] xor_chk;
  logic in_exec;
  assign sub_chk = work_q - dm_rdata_i;
  assign swap_chk = {dm_rdata_i[3:0], dm_rdata_i[7:4]};
  assign xor_chk = work_q ^ dm_rdata_i;
  assign in_exec = state_q == ext_exec_pkg::ST_EXEC;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_skip_taken;
    in_exec && skip_c;
  endsequence
  sequence s_skip_tail;
    (state_q == ext_exec_pkg::ST_DUMMY) && !done_o ##1 (done_o && skip_o && !busy_o);
  endsequence

  property p_sub_write;
    in_exec && op_q == ext_exec_pkg::OP_SUB_TO_MEMORY |=> dm_we_o && dm_wdata_o == $past(sub_chk);
  endproperty
  a_sub_write: assert property (p_sub_write) else $error("subtract result not written");
  property p_sub_borrow;
    in_exec && op_q == ext_exec_pkg::OP_SUB_TO_MEMORY
      |=> flags_o[ext_exec_pkg::FLAG_BORROW_INV] == ($past(work_q) >= $past(dm_rdata_i));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");
  property p_swap_mem;
    in_exec && op_q == ext_exec_pkg::OP_NIBBLE_SWAP_IN_PLACE
      |=> dm_we_o && dm_wdata_o == $past(swap_chk) && $stable(flags_o);
  endproperty
  a_swap_mem: assert property (p_swap_mem) else $error("in-place swap wrong");
  property p_swap_work;
    in_exec && op_q == ext_exec_pkg::OP_NIBBLE_SWAP_TO_WORK |=> !dm_we_o && work_o == $past(swap_chk) && $stable(flags_o);
  endproperty
  a_swap_work: assert property (p_swap_work) else $error("swap to work wrong");
  property p_skip_byte;
    in_exec && op_q == ext_exec_pkg::OP_SKIP_IF_ZERO_BYTE && dm_rdata_i != 8'h00 |=> !busy_o && done_o && !skip_o;
  endproperty
  a_skip_byte: assert property (p_skip_byte) else $error("byte skip taken wrongly");
  property p_skip_three;
    s_skip_taken |=> s_skip_tail;
  endproperty
  a_skip_three: assert property (p_skip_three) else $error("skip not three cycles");
  property p_load_skip;
    in_exec && op_q == ext_exec_pkg::OP_LOAD_SKIP_IF_ZERO |=> work_o == $past(dm_rdata_i);
  endproperty
  a_load_skip: assert property (p_load_skip) else $error("load skip copy wrong");
  property p_skip_bit;
    in_exec && op_q == ext_exec_pkg::OP_SKIP_IF_ZERO_BIT && !dm_rdata_i[bit_q] |=> state_q == ext_exec_pkg::ST_DUMMY;
  endproperty
  a_skip_bit: assert property (p_skip_bit) else $error("bit skip missed");
  property p_table_hi;
    in_exec && is_table(op_q) |=> table_high_latch_o == $past(pm_rdata_i[15:8]) && $stable(flags_o);
  endproperty
  a_table_hi: assert property (p_table_hi) else $error("table high latch wrong");
  property p_last_page;
    accept && op_i == ext_exec_pkg::OP_TABLE_READ_LAST_PAGE |=> pm_addr_o == {ext_exec_pkg::LAST_PAGE, $past(table_low_pointer_q)};
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong");
  property p_preinc;
    accept && preinc |=> table_low_pointer_o == $past(table_low_pointer_q) + 8'h01 && pm_addr_o[7:0] == table_low_pointer_o;
  endproperty
  a_preinc: assert property (p_preinc) else $error("pre-increment wrong");
  property p_xor_work;
    in_exec && op_q == ext_exec_pkg::OP_XOR_TO_WORK
      |=> work_o == $past(xor_chk) && flags_o[ext_exec_pkg::FLAG_ZERO] == (work_o == 8'h00);
  endproperty
  a_xor_work: assert property (p_xor_work) else $error("xor to work wrong");
  property p_xor_mem;
    in_exec && op_q == ext_exec_pkg::OP_XOR_TO_MEMORY
      |=> dm_wdata_o == $past(xor_chk) && flags_o[5:1] == $past(flags_q[5:1]);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");
endmodule

// *** rtl/ext_exec_alu.sv ***
// Combinational result and flag unit
`timescale 1ns/100ps
module ext_exec_alu (
  alu_if.alu a
);
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic wrap;

  assign diff = {1'b0, a.work} - {1'b0, a.mem};
  assign low_diff = {1'b0, a.work[3:0]} - {1'b0, a.mem[3:0]};
  // Signed wrap: operands differ in sign and result sign follows the subtrahend
  assign wrap = (a.work[7] != a.mem[7]) && (diff[7] != a.work[7]);

  always_comb begin
    a.result = a.mem;
    a.flags_out = a.flags_in;
    unique case (a.op)
      ext_exec_pkg::OP_SUB_TO_MEMORY: begin
        a.result = diff[7:0];
        a.flags_out[ext_exec_pkg::FLAG_ZERO] = (diff[7:0] == 8'h00);
        a.flags_out[ext_exec_pkg::FLAG_BORROW_INV] = ~diff[8];
        a.flags_out[ext_exec_pkg::FLAG_HALF_CARRY] = ~low_diff[4];
        a.flags_out[ext_exec_pkg::FLAG_SIGNED_WRAP] = wrap;
        a.flags_out[ext_exec_pkg::FLAG_SIGNED_BORROW] = ~(diff[7] ^ wrap);
        a.flags_out[ext_exec_pkg::FLAG_CHAINED_NIL] = (diff[7:0] == 8'h00);
      end
      ext_exec_pkg::OP_NIBBLE_SWAP_IN_PLACE, ext_exec_pkg::OP_NIBBLE_SWAP_TO_WORK: begin
        a.result = {a.mem[3:0], a.mem[7:4]};
      end
      ext_exec_pkg::OP_XOR_TO_WORK, ext_exec_pkg::OP_XOR_TO_MEMORY: begin
        a.result = a.work ^ a.mem;
        a.flags_out[ext_exec_pkg::FLAG_ZERO] = ((a.work ^ a.mem) == 8'h00);
      end
      default: begin
        a.result = a.mem;
      end
    endcase
  end
endmodule

// *** rtl/ext_exec_pkg.sv ***
// Shared constants and types for the extended instruction executor
package ext_exec_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PROG_W = 16;
  localparam int unsigned PROG_AW = 14;
  localparam int unsigned DATA_AW = 10;
  localparam int unsigned PAGE_W = 6;
  localparam int unsigned FLAG_W = 6;

  localparam logic [3:0] OP_SUB_TO_MEMORY = 4'h0;
  localparam logic [3:0] OP_NIBBLE_SWAP_IN_PLACE = 4'h1;
  localparam logic [3:0] OP_NIBBLE_SWAP_TO_WORK = 4'h2;
  localparam logic [3:0] OP_SKIP_IF_ZERO_BYTE = 4'h3;
  localparam logic [3:0] OP_LOAD_SKIP_IF_ZERO = 4'h4;
  localparam logic [3:0] OP_SKIP_IF_ZERO_BIT = 4'h5;
  localparam logic [3:0] OP_TABLE_READ_PAGED = 4'h6;
  localparam logic [3:0] OP_TABLE_READ_LAST_PAGE = 4'h7;
  localparam logic [3:0] OP_PREINC_TABLE_READ_PAGED = 4'h8;
  localparam logic [3:0] OP_PREINC_TABLE_READ_LAST = 4'h9;
  localparam logic [3:0] OP_XOR_TO_WORK = 4'hA;
  localparam logic [3:0] OP_XOR_TO_MEMORY = 4'hB;

  localparam int unsigned FLAG_ZERO = 0;
  localparam int unsigned FLAG_BORROW_INV = 1;
  localparam int unsigned FLAG_HALF_CARRY = 2;
  localparam int unsigned FLAG_SIGNED_WRAP = 3;
  localparam int unsigned FLAG_SIGNED_BORROW = 4;
  localparam int unsigned FLAG_CHAINED_NIL = 5;

  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] TABLE_LOW_POINTER_RST = 8'h00;
  localparam logic [7:0] TABLE_PAGE_POINTER_RST = 8'h00;
  localparam logic [7:0] TABLE_HIGH_LATCH_RST = 8'h00;
  localparam logic [5:0] LAST_PAGE = 6'h3F;
  localparam logic [2:0] BIT_RST = 3'h0;
  localparam logic [9:0] ADDR_RST = 10'h000;
  localparam logic [13:0] PM_ADDR_RST = 14'h0000;
  localparam logic [7:0] WDATA_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_DUMMY = 4'b1000
  } state_t;
endpackage

// *** verification/mem_model.sv ***
// Synchronous data and program memory arrays facing the executor
`timescale 1ns/100ps
module mem_model (
  input wire logic clk_sys_i,
  input wire logic [9:0] dm_addr_i,
  input wire logic dm_we_i,
  input wire logic [7:0] dm_wdata_i,
  input wire logic [13:0] pm_addr_i,
  output logic [7:0] dm_rdata_o,
  output logic [15:0] pm_rdata_o
);
  logic [7:0] dm_q [0:1023];
  logic [15:0] pm_q [0:16383];
  // Plain always: the bench preloads both arrays at time zero
  always @(posedge clk_sys_i) begin
    if (dm_we_i) begin
      dm_q[dm_addr_i] <= dm_wdata_i;
    end
  end
  // Write-first, so back-to-back use of one address sees the new byte
  always @(posedge clk_sys_i) begin
    dm_rdata_o <= dm_we_i ? dm_wdata_i : dm_q[dm_addr_i];
    pm_rdata_o <= pm_q[pm_addr_i];
  end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the extended instruction executor
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic skip;
    logic we;
    logic tbl;
    logic [7:0] wdata;
    logic [9:0] addr;
    logic [7:0] work;
    logic [5:0] flags;
    logic [7:0] table_high_latch;
    logic [7:0] table_low_pointer;
    logic [13:0] pma;
  } note_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic [3:0] op_v = 4'h0;
  logic [9:0] addr_v = 10'h000;
  logic [2:0] bit_v = 3'h0;
  logic work_load = 1'b0;
  logic [7:0] work_v = 8'h00;
  logic tbl_load = 1'b0;
  logic [7:0] table_low_pointer_v = 8'h00;
  logic [7:0] table_page_pointer_v = 8'h00;
  logic [7:0] dm_rdata;
  logic [15:0] pm_rdata;
  logic busy, done, skip, dm_we;
  logic [9:0] dm_addr;
  logic [7:0] dm_wdata, work, table_low_pointer, table_high_latch;
  logic [13:0] pm_addr;
  logic [5:0] flags;
  logic [7:0] dm_sh [0:1023];
  logic [7:0] w_sh, tl_sh, th_sh, tb_sh;
  logic [5:0] f_sh;
  integer seed = 32'h70c355ea;
  int mismatches = 0;
  int compares = 0;
  note_t notes[$];
  note_t mn;

  always #4 clk_sys = ~clk_sys;

  ext_exec u_ext_exec (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .start_i(start), .op_i(op_v),
    .addr_i(addr_v), .bit_sel_i(bit_v), .work_load_i(work_load), .work_i(work_v),
    .tbl_load_i(tbl_load), .table_low_pointer_i(table_low_pointer_v), .table_page_pointer_i(table_page_pointer_v), .dm_rdata_i(dm_rdata),
    .pm_rdata_i(pm_rdata), .busy_o(busy), .done_o(done), .skip_o(skip), .dm_addr_o(dm_addr),
    .dm_we_o(dm_we), .dm_wdata_o(dm_wdata), .pm_addr_o(pm_addr), .work_o(work),
    .flags_o(flags), .table_low_pointer_o(table_low_pointer), .table_high_latch_o(table_high_latch));
  mem_model u_mem_model (.clk_sys_i(clk_sys), .dm_addr_i(dm_addr), .dm_we_i(dm_we),
    .dm_wdata_i(dm_wdata), .pm_addr_i(pm_addr), .dm_rdata_o(dm_rdata), .pm_rdata_o(pm_rdata));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic load(input logic [7:0] w, input logic [7:0] p, input logic [7:0] h);
    @(posedge clk_sys);
    work_load <= 1'b1;
    work_v <= w;
    tbl_load <= 1'b1;
    table_low_pointer_v <= p;
    table_page_pointer_v <= h;
    @(posedge clk_sys);
    work_load <= 1'b0;
    tbl_load <= 1'b0;
    w_sh = w;
    tl_sh = p;
    tb_sh = h;
  endtask

  // Hold keeps start up and tries a work load while busy; both must be ignored
  task automatic exec(input logic [3:0] op, input logic [9:0] a, input logic [2:0] b, input bit hold);
    logic [7:0] m;
    logic [7:0] r;
    logic [15:0] pw;
    note_t n;
    int cyc;
    @(posedge clk_sys);
    start <= 1'b1;
    op_v <= op;
    addr_v <= a;
    bit_v <= b;
    @(posedge clk_sys);
    m = dm_sh[a];
    n = '0;
    case (op)
      ext_exec_pkg::OP_SUB_TO_MEMORY: begin
        r = w_sh - m;
        n.we = 1'b1;
        n.wdata = r;
        f_sh = {r == 8'h00, $signed(w_sh) >= $signed(m), (w_sh[7] ^ m[7]) & (r[7] ^ w_sh[7]),
          w_sh[3:0] >= m[3:0], w_sh >= m, r == 8'h00};
      end
      ext_exec_pkg::OP_NIBBLE_SWAP_IN_PLACE: begin
        n.we = 1'b1;
        n.wdata = {m[3:0], m[7:4]};
      end
      ext_exec_pkg::OP_NIBBLE_SWAP_TO_WORK: w_sh = {m[3:0], m[7:4]};
      ext_exec_pkg::OP_SKIP_IF_ZERO_BYTE: n.skip = (m == 8'h00);
      ext_exec_pkg::OP_LOAD_SKIP_IF_ZERO: begin
        w_sh = m;
        n.skip = (m == 8'h00);
      end
      ext_exec_pkg::OP_SKIP_IF_ZERO_BIT: n.skip = ~m[b];
      ext_exec_pkg::OP_XOR_TO_WORK: begin
        w_sh = w_sh ^ m;
        f_sh[0] = (w_sh == 8'h00);
      end
      ext_exec_pkg::OP_XOR_TO_MEMORY: begin
        n.we = 1'b1;
        n.wdata = w_sh ^ m;
        f_sh[0] = (n.wdata == 8'h00);
      end
      default: begin
        if (op == ext_exec_pkg::OP_PREINC_TABLE_READ_PAGED || op == ext_exec_pkg::OP_PREINC_TABLE_READ_LAST) begin
          tl_sh = tl_sh + 8'h01;
        end
        n.pma = {tb_sh[5:0], tl_sh};
        if (op == ext_exec_pkg::OP_TABLE_READ_LAST_PAGE || op == ext_exec_pkg::OP_PREINC_TABLE_READ_LAST) begin
          n.pma = {ext_exec_pkg::LAST_PAGE, tl_sh};
        end
        pw = u_mem_model.pm_q[n.pma];
        n.tbl = 1'b1;
        n.we = 1'b1;
        n.wdata = pw[7:0];
        th_sh = pw[15:8];
      end
    endcase
    if (n.we) begin
      dm_sh[a] = n.wdata;
    end
    n.addr = a;
    n.work = w_sh;
    n.flags = f_sh;
    n.table_high_latch = th_sh;
    n.table_low_pointer = tl_sh;
    notes.push_back(n);
    if (hold) begin
      work_load <= 1'b1;
      work_v <= ~w_sh;
      @(posedge clk_sys);
      work_load <= 1'b0;
    end
    start <= 1'b0;
    for (cyc = hold ? 2 : 1; cyc <= 8; cyc++) begin
      @(negedge clk_sys);
      if (done === 1'b1) break;
    end
    if (cyc > 8) begin
      mismatches++;
      complete_run();
    end else begin
      check(16'(cyc), n.skip ? 16'h0004 : 16'h0003);
      check({15'h0000, busy}, 16'h0000);
    end
  endtask

  always @(negedge clk_sys) begin
    if (reset_n === 1'b1 && done === 1'b1) begin
      if (notes.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        mn = notes.pop_front();
        check({15'h0000, skip}, {15'h0000, mn.skip});
        check({15'h0000, dm_we}, {15'h0000, mn.we});
        if (mn.we) begin
          check({6'h00, dm_addr}, {6'h00, mn.addr});
          check({8'h00, dm_wdata}, {8'h00, mn.wdata});
        end
        check({8'h00, work}, {8'h00, mn.work});
        check({10'h000, flags}, {10'h000, mn.flags});
        check({table_high_latch, table_low_pointer}, {mn.table_high_latch, mn.table_low_pointer});
        if (mn.tbl) begin
          check({2'b00, pm_addr}, {2'b00, mn.pma});
        end
      end
    end
  end

  initial begin
    for (int i = 0; i < 1024; i++) begin
      dm_sh[i] = (i % 4 == 0) ? 8'h00 : 8'($random(seed));
      u_mem_model.dm_q[i] = dm_sh[i];
    end
    for (int i = 0; i < 16384; i++) begin
      u_mem_model.pm_q[i] = 16'($random(seed));
    end
    {w_sh, tl_sh, tb_sh, th_sh, f_sh} = '0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    check({work, table_low_pointer}, 16'h0000);
    check({2'b00, flags, table_high_latch}, 16'h0000);
    // Pointer wrap from FF and a zero-result subtract
    load(8'h00, 8'hFF, 8'h3F);
    exec(ext_exec_pkg::OP_PREINC_TABLE_READ_PAGED, 10'h001, 3'h0, 1'b0);
    exec(ext_exec_pkg::OP_SUB_TO_MEMORY, 10'h000, 3'h0, 1'b0);
    exec(ext_exec_pkg::OP_PREINC_TABLE_READ_LAST, 10'h3FF, 3'h7, 1'b1);
    for (int k = 0; k < 240; k++) begin
      if (k % 6 == 0) begin
        load(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
      end
      exec(4'(k % 12), 10'($random(seed) & 15), 3'($random(seed)), k % 5 == 0);
    end
    complete_run();
  end
endmodule
